/* rtl/static_class_pkg.sv */
// Constants shared by the static frame classifier
package static_class_pkg;
	// Header bytes kept per frame: DA, SA, two VLAN tags, SecTAG up to PN
	localparam int HDR_BYTES = 30;
	localparam int POS_W = 5;
	localparam int DA_CMP_COUNT = 8;
	localparam int CRIT_COUNT = 29;
	localparam int ET_SEL_COUNT = 18;
	// Reset values of the writable address compares, then the fixed SecTAG EtherType and SL limit
	localparam logic [47:0] FIXED_DA_RST = 48'h0100_0CCC_CCCC;
	localparam logic [43:0] PREFIX_DA_RST = 44'h0180_C200_000;
	localparam logic [15:0] SECTAG_TYPE = 16'h88E5;
	localparam logic [5:0] SL_LIMIT = 6'h30;
	// Byte offsets in the frame
	localparam logic [4:0] OFS_TYPE0 = 5'h0C;
	localparam logic [4:0] OFS_TYPE1 = 5'h10;
	localparam logic [4:0] OFS_TYPE2 = 5'h14;
	// TCI bit positions
	localparam int TCI_V = 7;
	localparam int TCI_ES = 6;
	localparam int TCI_SC = 5;
	localparam int TCI_SCB = 4;
	localparam int TCI_E = 3;
	localparam int TCI_C = 2;
	// Tag check enable bits
	localparam int CHK_V = 0;
	localparam int CHK_CE = 1;
	localparam int CHK_SCES = 2;
	localparam int CHK_SCB = 3;
	localparam int CHK_SL = 4;
	localparam int CHK_PN = 5;
	// Criterion enable mask layout
	localparam int EN_DA = 0;
	localparam int EN_ET_LO = 8;
	localparam int EN_ET_HI = 16;
	localparam int EN_COMBO = 24;
	localparam int EN_FIXED = 26;
	localparam int EN_PREFIX = 27;
	localparam int EN_RANGE = 28;
	// Tag parse classes
	localparam logic [1:0] CLASS_UNTAGGED = 2'h0;
	localparam logic [1:0] CLASS_BAD = 2'h1;
	localparam logic [1:0] CLASS_KAY = 2'h2;
	localparam logic [1:0] CLASS_TAGGED = 2'h3;
endpackage

/* rtl/static_frame_classifier.sv */
// Static frame classifier: control bit, SecTAG class and VLAN parse per frame
module static_frame_classifier (
	input wire logic mclk_i,
	input wire logic srst_i,
	input wire logic in_valid_i,
	input wire logic [7:0] in_data_i,
	input wire logic in_last_i,
	output logic in_ready_o,
	input wire logic fixed_da_wr_i,
	input wire logic [47:0] fixed_da_i,
	input wire logic prefix_da_wr_i,
	input wire logic [43:0] prefix_da_i,
	input wire logic [47:0] da_range_low_i,
	input wire logic [47:0] da_range_high_i,
	input wire logic [383:0] da_compare_n_i,
	input wire logic [255:0] ethertype_compare_n_i,
	input wire logic [95:0] da_and_type_da_i,
	input wire logic [31:0] da_and_type_et_i,
	input wire logic [17:0] ethertype_source_select_i,
	input wire logic enable_wr_i,
	input wire logic [28:0] criterion_enable_mask_i,
	input wire logic [5:0] tag_check_config_i,
	input wire logic vlan_bypass_i,
	input wire logic prio_enable_i,
	input wire logic [2:0] default_prio_i,
	input wire logic [15:0] qtag_type_i,
	input wire logic [15:0] stag_type_i,
	input wire logic [23:0] inner_priority_remap_i,
	input wire logic res_ready_i,
	output logic res_valid_o,
	output logic control_o,
	output logic [1:0] tag_class_o,
	output logic vlan_valid_o,
	output logic stag_valid_o,
	output logic qtag_valid_o,
	output logic qinq_o,
	output logic [2:0] user_prio_o,
	output logic [11:0] vlan_id_o,
	output logic [2:0] inner_prio_o,
	output logic [11:0] inner_vid_o,
	output logic [15:0] parsed_type_o
);

	////////////////////////////////////////////////////////////////////////////
	logic [7:0] hdr_r [0:static_class_pkg::HDR_BYTES-1];
	logic [7:0] hv [0:static_class_pkg::HDR_BYTES-1];
	logic [7:0] tb [0:7];
	logic [static_class_pkg::POS_W-1:0] pos_r;
	logic [47:0] fixed_da_r;
	logic [43:0] prefix_da_r;
	logic [28:0] enable_r;
	logic beat, done;
	logic [47:0] da;
	logic [15:0] type0, type1, type2, parsed, sec_type;
	logic vlan1, vlan2, is_s;
	logic [4:0] sec_base;
	logic [7:0] tci;
	logic [31:0] pn;
	logic [1:0] tag_class;
	logic [28:0] hits;
	logic [2:0] up, inner_up;

	assign beat = in_valid_i && in_ready_o;
	assign done = beat && in_last_i;

	////////////////////////////////////////////////////////////////////////////
	// Header capture; short frames read as zero past their end
	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			pos_r <= '0;
		end else if (beat) begin
			if (in_last_i) begin
				pos_r <= '0;
			end else if (pos_r != static_class_pkg::POS_W'(static_class_pkg::HDR_BYTES)) begin
				pos_r <= pos_r + 5'h01;
			end
		end
	end

	always_ff @(posedge mclk_i) begin
		if (beat && pos_r < static_class_pkg::POS_W'(static_class_pkg::HDR_BYTES)) begin
			hdr_r[pos_r] <= in_data_i;
		end
	end

	// Last byte is folded in directly so results land at the end beat
	always_comb begin
		for (int i = 0; i < static_class_pkg::HDR_BYTES; i++) begin
			if (static_class_pkg::POS_W'(i) < pos_r) begin
				hv[i] = hdr_r[i];
			end else if (beat && static_class_pkg::POS_W'(i) == pos_r) begin
				hv[i] = in_data_i;
			end else begin
				hv[i] = 8'h00;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Writable compare values and enables
	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			fixed_da_r <= static_class_pkg::FIXED_DA_RST;
		end else if (fixed_da_wr_i) begin
			fixed_da_r <= fixed_da_i;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			prefix_da_r <= static_class_pkg::PREFIX_DA_RST;
		end else if (prefix_da_wr_i) begin
			prefix_da_r <= prefix_da_i;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			enable_r <= '0;
		end else if (enable_wr_i) begin
			enable_r <= criterion_enable_mask_i;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// VLAN parse
	assign da = {hv[0], hv[1], hv[2], hv[3], hv[4], hv[5]};
	assign type0 = {hv[12], hv[13]};
	assign type1 = {hv[16], hv[17]};
	assign type2 = {hv[20], hv[21]};
	assign is_s = (type0 == stag_type_i);
	assign vlan1 = is_s || (type0 == qtag_type_i);
	assign vlan2 = vlan1 && (type1 == stag_type_i || type1 == qtag_type_i);
	assign parsed = vlan2 ? type2 : (vlan1 ? type1 : type0);
	assign up = (vlan1 && prio_enable_i) ? hv[14][7:5] : default_prio_i;
	assign inner_up = inner_priority_remap_i[3*hv[18][7:5] +: 3];

	////////////////////////////////////////////////////////////////////////////
	// SecTAG parse; only bypass mode looks past VLAN tags
	always_comb begin
		sec_base = static_class_pkg::OFS_TYPE0;
		if (vlan_bypass_i && vlan2) begin
			sec_base = static_class_pkg::OFS_TYPE2;
		end else if (vlan_bypass_i && vlan1) begin
			sec_base = static_class_pkg::OFS_TYPE1;
		end
		for (int j = 0; j < 8; j++) begin
			tb[j] = hv[sec_base + 5'(j)];
		end
	end

	assign sec_type = {tb[0], tb[1]};
	assign tci = tb[2];
	assign pn = {tb[4], tb[5], tb[6], tb[7]};

	always_comb begin
		if (sec_type != static_class_pkg::SECTAG_TYPE) begin
			tag_class = static_class_pkg::CLASS_UNTAGGED;
		end else if (tag_check_config_i[static_class_pkg::CHK_V] && tci[static_class_pkg::TCI_V]) begin
			tag_class = static_class_pkg::CLASS_BAD;
		end else if (!tci[static_class_pkg::TCI_C] && tci[static_class_pkg::TCI_E]) begin
			tag_class = static_class_pkg::CLASS_KAY;
		end else if ((tag_check_config_i[static_class_pkg::CHK_CE] && tci[static_class_pkg::TCI_C]
				&& !tci[static_class_pkg::TCI_E])
				|| (tag_check_config_i[static_class_pkg::CHK_SCES] && tci[static_class_pkg::TCI_SC]
				&& tci[static_class_pkg::TCI_ES])
				|| (tag_check_config_i[static_class_pkg::CHK_SCB] && tci[static_class_pkg::TCI_SC]
				&& tci[static_class_pkg::TCI_SCB])
				|| (tag_check_config_i[static_class_pkg::CHK_SL] && tb[3][5:0] >= static_class_pkg::SL_LIMIT)
				|| (tag_check_config_i[static_class_pkg::CHK_PN] && pn == 32'h0000_0000)) begin
			tag_class = static_class_pkg::CLASS_BAD;
		end else begin
			tag_class = static_class_pkg::CLASS_TAGGED;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Control criteria; a type compare picks its own source per index
	always_comb begin
		for (int k = 0; k < static_class_pkg::DA_CMP_COUNT; k++) begin
			hits[static_class_pkg::EN_DA + k] = (da == da_compare_n_i[48*k +: 48]);
			hits[static_class_pkg::EN_ET_LO + k] =
				((ethertype_source_select_i[k] ? parsed : type0) == ethertype_compare_n_i[16*k +: 16]);
			hits[static_class_pkg::EN_ET_HI + k] = ((ethertype_source_select_i[10 + k] ? parsed : type0)
				== ethertype_compare_n_i[16*(8 + k) +: 16]);
		end
		for (int c = 0; c < 2; c++) begin
			hits[static_class_pkg::EN_COMBO + c] = (da == da_and_type_da_i[48*c +: 48])
				&& ((ethertype_source_select_i[8 + c] ? parsed : type0) == da_and_type_et_i[16*c +: 16]);
		end
		hits[static_class_pkg::EN_FIXED] = (da == fixed_da_r);
		hits[static_class_pkg::EN_PREFIX] = (da[47:4] == prefix_da_r);
		hits[static_class_pkg::EN_RANGE] = (da >= da_range_low_i) && (da <= da_range_high_i);
	end

	////////////////////////////////////////////////////////////////////////////
	// Result hand-off; input stalls while a result waits, one set per frame
	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			res_valid_o <= 1'b0;
			in_ready_o <= 1'b0;
		end else if (done) begin
			res_valid_o <= 1'b1;
			in_ready_o <= 1'b0;
		end else if (res_valid_o && res_ready_i) begin
			res_valid_o <= 1'b0;
			in_ready_o <= 1'b1;
		end else if (!res_valid_o) begin
			in_ready_o <= 1'b1;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			control_o <= 1'b0;
			tag_class_o <= static_class_pkg::CLASS_UNTAGGED;
		end else if (done) begin
			control_o <= |(hits & enable_r);
			tag_class_o <= tag_class;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			vlan_valid_o <= 1'b0;
			stag_valid_o <= 1'b0;
			qtag_valid_o <= 1'b0;
			qinq_o <= 1'b0;
			user_prio_o <= '0;
			vlan_id_o <= '0;
			inner_prio_o <= '0;
			inner_vid_o <= '0;
			parsed_type_o <= '0;
		end else if (done) begin
			vlan_valid_o <= vlan1;
			stag_valid_o <= vlan1 && is_s;
			qtag_valid_o <= vlan1 && !is_s;
			qinq_o <= vlan2;
			user_prio_o <= up;
			vlan_id_o <= {hv[14][3:0], hv[15]};
			inner_prio_o <= inner_up;
			inner_vid_o <= {hv[18][3:0], hv[19]};
			parsed_type_o <= parsed;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (srst_i);

	hold_stable_a: assert property (res_valid_o && !res_ready_i |=> res_valid_o
		&& $stable({control_o, tag_class_o, parsed_type_o, vlan_id_o, user_prio_o, inner_prio_o, inner_vid_o})
		&& $stable({vlan_valid_o, stag_valid_o, qtag_valid_o, qinq_o}))
		else $error("result changed before taken");
	stall_after_last_a: assert property (done |=> res_valid_o && !in_ready_o)
		else $error("input not stalled after frame end");
	reset_disabled_a: assert property ($past(srst_i) |-> enable_r == 29'h000_0000
		&& fixed_da_r == static_class_pkg::FIXED_DA_RST && prefix_da_r == static_class_pkg::PREFIX_DA_RST)
		else $error("criteria or compare value wrong after reset");
	none_enabled_a: assert property (done && enable_r == 29'h000_0000 |=> !control_o)
		else $error("control set with no criterion enabled");
	full_range_a: assert property (done && enable_r[static_class_pkg::EN_RANGE]
		&& da_range_low_i == 48'h0000_0000_0000 && da_range_high_i == 48'hFFFF_FFFF_FFFF |=> control_o)
		else $error("full range did not classify control");
	untagged_type_a: assert property (done && type0 != static_class_pkg::SECTAG_TYPE && !vlan_bypass_i
		|=> tag_class_o == static_class_pkg::CLASS_UNTAGGED)
		else $error("non-MACsec type not untagged");
	kay_class_a: assert property (done && sec_type == static_class_pkg::SECTAG_TYPE
		&& !tci[static_class_pkg::TCI_V] && tci[static_class_pkg::TCI_E] && !tci[static_class_pkg::TCI_C]
		|=> tag_class_o == static_class_pkg::CLASS_KAY)
		else $error("KaY tag misclassified");
	default_prio_a: assert property (done && (!vlan1 || !prio_enable_i)
		|=> user_prio_o == $past(default_prio_i))
		else $error("default priority not used");
	flag_consistency_a: assert property (res_valid_o |-> (!qinq_o || vlan_valid_o)
		&& !(stag_valid_o && qtag_valid_o) && (vlan_valid_o == (stag_valid_o || qtag_valid_o)))
		else $error("VLAN flags inconsistent");

	kay_seen_c: cover property (done ##1 tag_class_o == static_class_pkg::CLASS_KAY);
	qinq_seen_c: cover property (done ##1 qinq_o);
	control_seen_c: cover property (done ##1 control_o);
	// Sink stalls two cycles before taking, so a longer run is never seen
	backpressure_c: cover property ((res_valid_o && !res_ready_i) [*2] ##1 res_ready_i);

endmodule

/* tb/frame_partner.sv */
// Frame source and stalling result sink that face the classifier
module frame_partner (
	input wire logic mclk_i,
	input wire logic in_ready_i,
	input wire logic res_valid_i,
	output logic in_valid_o,
	output logic [7:0] in_data_o,
	output logic in_last_o,
	output logic res_ready_o
);
	timeunit 1ns;
	timeprecision 1ns;
	int held;
	initial begin
		in_valid_o = 1'b0;
		in_data_o = 8'h00;
		in_last_o = 1'b0;
		res_ready_o = 1'b0;
		held = 0;
	end
	// Sends 30 header bytes, DA first; each byte stands until it is taken
	task automatic send(input logic [239:0] f);
		for (int i = 0; i < 30; i++) begin
			in_valid_o <= 1'b1;
			in_data_o <= f[239 - 8 * i -: 8];
			in_last_o <= (i == 29);
			@(posedge mclk_i);
			while (in_ready_i !== 1'b1) @(posedge mclk_i);
		end
		in_valid_o <= 1'b0;
		in_last_o <= 1'b0;
		// Idle data flips so a stale byte never looks valid
		in_data_o <= ~in_data_o;
	endtask
	// Takes each result only after two stalled cycles, so results must stand
	always @(posedge mclk_i) begin
		held <= res_valid_i ? held + 1 : 0;
		res_ready_o <= res_valid_i && held == 1 && !res_ready_o;
	end
endmodule

/* tb/static_frame_classifier_tb_top.sv */
// Self-checking bench for the static frame classifier
module static_frame_classifier_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic mclk_i, srst_i, iv, il, ir, rr, rv, fw, ew, byp, pe, ctl, vv, sv, qv, qq;
	logic [7:0] id;
	logic [47:0] fd, lo, hi;
	logic [43:0] pd;
	logic [383:0] dc;
	logic [255:0] ec;
	logic [95:0] cd;
	logic [31:0] ce;
	logic [17:0] sel;
	logic [28:0] em;
	logic [5:0] cfg;
	logic [2:0] dp, up, ip;
	logic [23:0] rm;
	logic [1:0] tc;
	logic [11:0] vid, ivid;
	logic [15:0] pt;
	int fails, n_checks;
	////////////////////////////////////////////////////////////////////////
	static_frame_classifier dut (
		.mclk_i(mclk_i), .srst_i(srst_i), .in_valid_i(iv), .in_data_i(id), .in_last_i(il), .in_ready_o(ir),
		.fixed_da_wr_i(fw), .fixed_da_i(fd), .prefix_da_wr_i(fw), .prefix_da_i(pd),
		.da_range_low_i(lo), .da_range_high_i(hi), .da_compare_n_i(dc), .ethertype_compare_n_i(ec),
		.da_and_type_da_i(cd), .da_and_type_et_i(ce), .ethertype_source_select_i(sel), .enable_wr_i(ew),
		.criterion_enable_mask_i(em), .tag_check_config_i(cfg), .vlan_bypass_i(byp), .prio_enable_i(pe),
		.default_prio_i(dp), .qtag_type_i(16'h8100), .stag_type_i(16'h88A8), .inner_priority_remap_i(rm),
		.res_ready_i(rr), .res_valid_o(rv), .control_o(ctl), .tag_class_o(tc), .vlan_valid_o(vv),
		.stag_valid_o(sv), .qtag_valid_o(qv), .qinq_o(qq), .user_prio_o(up), .vlan_id_o(vid),
		.inner_prio_o(ip), .inner_vid_o(ivid), .parsed_type_o(pt)
	);
	frame_partner src (
		.mclk_i(mclk_i), .in_ready_i(ir), .res_valid_i(rv), .in_valid_o(iv), .in_data_o(id), .in_last_o(il),
		.res_ready_o(rr)
	);
	initial begin
		mclk_i = 1'b0;
		forever #20 mclk_i = ~mclk_i;
	end
	////////////////////////////////////////////////////////////////////////
	task automatic summarize();
		if (fails == 0 && n_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp) begin
			fails++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	function automatic logic [239:0] mk(input logic [47:0] da, input logic [15:0] t, input logic [127:0] r);
		return {da, 48'h0200_0000_0001, t, r};
	endfunction
	// Sends a frame and returns in the first cycle its results are valid
	task automatic go(input logic [239:0] f);
		int n;
		src.send(f);
		n = 0;
		do begin
			@(posedge mclk_i);
			n++;
		end while (rv !== 1'b1 && n < 40);
		if (rv !== 1'b1) fails++;
	endtask
	task automatic en(input logic [28:0] m);
		em <= m;
		ew <= 1'b1;
		@(posedge mclk_i);
		ew <= 1'b0;
	endtask
	task automatic ct(input logic [28:0] m, input logic [239:0] f, input logic e);
		en(m);
		go(f);
		chk("control", ctl, e);
	endtask
	task automatic tg(input logic [7:0] tci, input logic [7:0] sl, input logic [31:0] pn, input logic [1:0] e);
		go(mk(48'h2, 16'h88E5, {tci, sl, pn, 80'h0}));
		chk("tag_class", tc, e);
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (10000) @(posedge mclk_i);
		fails++;
		summarize();
	end
	initial begin
		srst_i = 1'b1;
		fw = 1'b0;
		ew = 1'b0;
		fd = 48'h0A0B_0C0D_0E0F;
		pd = 44'h123_4567_89AB;
		lo = 48'h1234_5678_9ABC;
		hi = 48'h1234_5678_9ABC;
		for (int k = 0; k < 16; k++) begin
			if (k < 8) dc[k * 48 +: 48] = 48'h0A00_0000_0000 + 48'(k);
			ec[k * 16 +: 16] = 16'h9000 + 16'(k);
		end
		cd = {48'h0, 48'h0C00_0000_0001};
		ce = {16'h0, 16'h9100};
		sel = 18'h0_0000;
		em = 29'h0;
		cfg = 6'h3F;
		byp = 1'b0;
		pe = 1'b1;
		dp = 3'h5;
		// Reversed order, so a missing remap shows
		rm = {3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6, 3'h7};
		fails = 0;
		n_checks = 0;
		repeat (4) @(posedge mclk_i);
		srst_i <= 1'b0;
		@(posedge mclk_i);
		chk("res_valid", rv, 1'b0);
		ct(29'h0, mk(48'h0100_0CCC_CCCC, 16'h0800, 128'h0), 1'b0);
		ct(29'h1 << 26, mk(48'h0100_0CCC_CCCC, 16'h0800, 128'h0), 1'b1);
		ct(29'h1 << 27, mk(48'h0180_C200_000E, 16'h0800, 128'h0), 1'b1);
		ct(29'h1 << 27, mk(48'h0180_C200_001E, 16'h0800, 128'h0), 1'b0);
		fw <= 1'b1;
		@(posedge mclk_i);
		fw <= 1'b0;
		ct(29'h1 << 26, mk(48'h0A0B_0C0D_0E0F, 16'h0800, 128'h0), 1'b1);
		ct(29'h1 << 27, mk(48'h1234_5678_9AB7, 16'h0800, 128'h0), 1'b1);
		ct(29'h1 << 27, mk(48'h0180_C200_000E, 16'h0800, 128'h0), 1'b0);
		ct(29'h1 << 28, mk(48'h1234_5678_9ABC, 16'h0800, 128'h0), 1'b1);
		ct(29'h1 << 28, mk(48'h1234_5678_9ABD, 16'h0800, 128'h0), 1'b0);
		ct(29'h1 << 28, mk(48'h1234_5678_9ABB, 16'h0800, 128'h0), 1'b0);
		for (int k = 0; k < 8; k++) begin
			ct(29'h1 << k, mk(48'h0A00_0000_0000 + 48'(k), 16'h0800, 128'h0), 1'b1);
			ct(29'h1 << ((k + 1) % 8), mk(48'h0A00_0000_0000 + 48'(k), 16'h0800, 128'h0), 1'b0);
		end
		for (int k = 0; k < 16; k++) begin
			ct(29'h1 << (8 + k), mk(48'h2, 16'h9000 + 16'(k), 128'h0), 1'b1);
		end
		ct(29'h0FFF_FFFF, mk(48'h2, 16'h0800, 128'h0), 1'b0);
		ct(29'h1FFF_FFFF, mk(48'h1234_5678_9ABC, 16'h0800, 128'h0), 1'b1);
		ct(29'h101, mk(48'h2, 16'h9000, 128'h0), 1'b1);
		ct(29'h101, mk(48'h0A00_0000_0000, 16'h0800, 128'h0), 1'b1);
		ct(29'h1 << 24, mk(48'h0C00_0000_0001, 16'h0800, 128'h0), 1'b0);
		ct(29'h1 << 24, mk(48'h0C00_0000_0001, 16'h9100, 128'h0), 1'b1);
		ct(29'h100, mk(48'h2, 16'h8100, {16'h6123, 16'h9000, 96'h0}), 1'b0);
		sel <= 18'h0_0001;
		ct(29'h100, mk(48'h2, 16'h8100, {16'h6123, 16'h9000, 96'h0}), 1'b1);
		tg(8'h0C, 8'h00, 32'h1, 2'h3);
		tg(8'h80, 8'h00, 32'h1, 2'h1);
		tg(8'h08, 8'h00, 32'h1, 2'h2);
		chk("control", ctl, 1'b0);
		tg(8'h04, 8'h00, 32'h1, 2'h1);
		tg(8'h60, 8'h00, 32'h1, 2'h1);
		tg(8'h30, 8'h00, 32'h1, 2'h1);
		tg(8'h00, 8'h30, 32'h1, 2'h1);
		tg(8'h00, 8'h2F, 32'h1, 2'h3);
		tg(8'h00, 8'h00, 32'h0, 2'h1);
		cfg <= 6'h00;
		tg(8'h80, 8'h00, 32'h1, 2'h3);
		go(mk(48'h2, 16'h8100, {16'h6123, 16'h88E5, 16'h0000, 32'h1, 48'h0}));
		chk("tag_class", tc, 2'h0);
		byp <= 1'b1;
		go(mk(48'h2, 16'h8100, {16'h6123, 16'h88E5, 16'h0000, 32'h1, 48'h0}));
		chk("tag_class", tc, 2'h3);
		byp <= 1'b0;
		go(mk(48'h2, 16'h0800, 128'h0));
		chk("tag_class", tc, 2'h0);
		chk("vlan_valid", vv, 1'b0);
		chk("user_prio", up, 3'h5);
		chk("parsed_type", pt, 16'h0800);
		go(mk(48'h2, 16'h8100, {16'h6123, 16'h0806, 96'h0}));
		chk("flags", {vv, sv, qv, qq}, 4'b1010);
		chk("user_prio", up, 3'h3);
		chk("vlan_id", vid, 12'h123);
		chk("parsed_type", pt, 16'h0806);
		go(mk(48'h2, 16'h88A8, {16'h2456, 16'h8100, 16'hE789, 16'h86DD, 64'h0}));
		chk("flags", {vv, sv, qv, qq}, 4'b1101);
		chk("user_prio", up, 3'h1);
		chk("vlan_id", vid, 12'h456);
		chk("inner_vid", ivid, 12'h789);
		chk("inner_prio", ip, 3'h0);
		chk("parsed_type", pt, 16'h86DD);
		pe <= 1'b0;
		go(mk(48'h2, 16'h8100, {16'h6123, 16'h0806, 96'h0}));
		chk("user_prio", up, 3'h5);
		summarize();
	end
endmodule
